// ### design/sbir_regs.svh
/*
 Register map, field positions, reset values and timing for the interrupt and transceiver bank.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef SBIR_REGS_SVH
`define SBIR_REGS_SVH
`define SBIR_ADDR_W          10
`define SBIR_ADDR_MODE_CTL   10'h01A
`define SBIR_ADDR_SUPPLY_STS 10'h01B
`define SBIR_ADDR_MASK_ONE   10'h01D
`define SBIR_ADDR_MASK_TWO   10'h01E
`define SBIR_ADDR_MODE_CHK   10'h01F
`define SBIR_ADDR_SRC_ONE    10'h021
`define SBIR_ADDR_SRC_TWO    10'h022
`define SBIR_ADDR_XCVR       10'h024
`define SBIR_MODE_WDG_OFF    3'h3
`define SBIR_MODE_NORMAL     3'h2
`define SBIR_XCVR_TERM       3'h0
`define SBIR_XCVR_RX_ONLY    3'h2
`define SBIR_XCVR_RX_TX      3'h3
`define SBIR_XCVR_OT_BIT     3
`define SBIR_STS_OVL_BIT     1
`define SBIR_NR_TIME_MS      75
`define SBIR_CLK_MHZ         250
`define SBIR_NR_CYCLES       (`SBIR_NR_TIME_MS * 1000 * `SBIR_CLK_MHZ)
`define SBIR_ZERO8           8'h00
`endif

// ### design/sbir_pkg.sv
/*
 Types for the interrupt and transceiver register bank.
 Assumes sbir_regs.svh is on the include path.
*/
`include "sbir_regs.svh"
package sbir_pkg;
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`SBIR_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
  } sbir_acc_type;
  typedef struct packed {
    logic battery_overvoltage;
    logic battery_undervoltage;
    logic switch_overheat;
    logic second_supply_on;
    logic regulator_overheat;
    logic regulator_prewarning;
    logic can_line_fault;
    logic serial_error;
    logic wake_event;
    logic transceiver_overheat;
    logic force_term;
  } sbir_evt_type;
  typedef enum logic [1:0] {
    SBIR_NORMAL_REQUEST,
    SBIR_NORMAL,
    SBIR_STANDBY,
    SBIR_SLEEP
  } sbir_mode_type;
endpackage

// ### design/sbir_bank.sv
/*
 Interrupt mask, interrupt source, supply status and transceiver control bank with
 operating mode tracking. Assumes the SPI front end delivers one-cycle access strobes
 on i_clk, and that event inputs are asynchronous analog-side levels.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sbir_regs.svh"
// Functional notes
// - Battery overvoltage status is live, never cleared by any access.
// - Switch overheat, second supply on, undervoltage latch; cleared by status read.
// - Mask one at 01D: high voltage b3, overheat b2, prewarning b1, undervoltage b0.
// - Mask two at 01E: CAN fault b2, SPI error b1, wake-up b0.
// - Mask bit one enables its interrupt, zero disables it.
// - Power-on reset or reset pin low clears all mask bits.
// - Source bits mirror flags held in other status registers.
// - Source reads never clear; bits follow underlying flags only.
// - Source one at 021 read-only, four flags bits 3..0, zero after reset.
// - Source two at 022 read-only, three flags bits 2..0, zero after reset.
// - Transceiver low bits select terminated, receive only, receive-transmit; reads state.
// - Effective transceiver state also gated by the chip operating mode.
// - Transceiver bit 3 latches overtemperature until the transceiver register is read.
// - Any forced termination also clears the two lowest control bits.
// - Power-on reset clears transceiver register; reset pin alone leaves it.
// - After power-up wait 75 ms for trigger word, else sleep, main regulator off.
// - Watchdog disable: in stand-by, write 011 to mode control then mode check.
// - Without watchdog, second regulator cannot switch on and transceiver unusable.
module sbir_bank #(
  parameter int NR_CYCLES = `SBIR_NR_CYCLES
) (
  // Clock and resets
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_rst_pin_n,
  // Register access
  input  wire sbir_pkg::sbir_acc_type i_acc,
  output logic [7:0]         o_rdata,
  // Status events
  input  wire sbir_pkg::sbir_evt_type i_evt,
  input  wire logic          i_v2_request,
  // Outputs
  output logic               o_irq,
  output logic [2:0]         o_xcvr_state,
  output logic               o_main_reg_on,
  output logic               o_second_reg_on,
  output logic               o_wdg_enabled,
  output logic [1:0]         o_mode
);
  import sbir_pkg::*;

  // Three-stage synchroniser; a change counts once stages two and three agree
  sbir_evt_type s1_ff, s2_ff, s3_ff, evt_ff;
  sbir_evt_type nxt_evt;
  always_comb begin
    nxt_evt = evt_ff;
    if (s2_ff == s3_ff) begin
      nxt_evt = s3_ff;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      evt_ff <= '0;
    end else begin
      s1_ff  <= i_evt;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      evt_ff <= nxt_evt;
    end
  end
  logic rp1_ff, rp2_ff, rp3_ff, rst_pin_low_ff;
  logic nxt_rst_pin_low;
  always_comb begin
    nxt_rst_pin_low = rst_pin_low_ff;
    if (rp2_ff == rp3_ff) begin
      nxt_rst_pin_low = ~rp3_ff;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rp1_ff         <= 1'b1;
      rp2_ff         <= 1'b1;
      rp3_ff         <= 1'b1;
      rst_pin_low_ff <= 1'b0;
    end else begin
      rp1_ff         <= i_rst_pin_n;
      rp2_ff         <= rp1_ff;
      rp3_ff         <= rp2_ff;
      rst_pin_low_ff <= nxt_rst_pin_low;
    end
  end

  function automatic logic hit(input sbir_acc_type a, input logic [`SBIR_ADDR_W-1:0] adr);
    hit = (a.addr == adr);
  endfunction
  // Forced termination decode, shared by the next-state logic and its check
  function automatic logic force_hit(input sbir_evt_type e);
    force_hit = e.force_term | e.transceiver_overheat;
  endfunction

  // Status latches, masks, transceiver and mode state
  logic [2:0]    sts_lat_ff, nxt_sts_lat;
  logic [3:0]    mask1_ff, nxt_mask1;
  logic [2:0]    mask2_ff, nxt_mask2;
  logic [2:0]    xctl_ff, nxt_xctl;
  logic          tot_ff, nxt_tot;
  logic          armed_ff, nxt_armed;
  sbir_mode_type mode_ff, nxt_mode;
  logic [31:0]   nr_cnt_ff, nxt_nr_cnt;
  logic          wdg_ff, nxt_wdg;
  logic [2:0]    xstate;
  logic [3:0]    src1;
  logic [2:0]    src2;
  logic          rd_sts, rd_x;
  assign rd_sts = i_acc.rd && hit(i_acc, `SBIR_ADDR_SUPPLY_STS);
  assign rd_x   = i_acc.rd && hit(i_acc, `SBIR_ADDR_XCVR);
  // Mirrors of the status flags; no storage of their own, so source reads cannot clear them
  assign src1 = {evt_ff.battery_overvoltage, evt_ff.regulator_overheat,
                 evt_ff.regulator_prewarning, sts_lat_ff[0]};
  assign src2 = {evt_ff.can_line_fault, evt_ff.serial_error,
                 evt_ff.wake_event};
  // Transceiver only runs in normal mode with the watchdog active
  assign xstate = (mode_ff == SBIR_NORMAL && wdg_ff) ? xctl_ff
                : `SBIR_XCVR_TERM;

  always_comb begin
    // Latched bits: set wins over the read clear
    nxt_sts_lat = rd_sts ? 3'h0 : sts_lat_ff;
    nxt_sts_lat = nxt_sts_lat | {evt_ff.switch_overheat, evt_ff.second_supply_on,
                                 evt_ff.battery_undervoltage};
    nxt_mask1 = mask1_ff;
    nxt_mask2 = mask2_ff;
    if (i_acc.wr && hit(i_acc, `SBIR_ADDR_MASK_ONE)) begin
      nxt_mask1 = i_acc.wdata[3:0];
    end
    if (i_acc.wr && hit(i_acc, `SBIR_ADDR_MASK_TWO)) begin
      nxt_mask2 = i_acc.wdata[2:0];
    end
    if (rst_pin_low_ff) begin
      nxt_mask1 = 4'h0;
      nxt_mask2 = 3'h0;
    end
    nxt_xctl = xctl_ff;
    if (i_acc.wr && hit(i_acc, `SBIR_ADDR_XCVR)) begin
      case (i_acc.wdata[2:0])
        `SBIR_XCVR_TERM, `SBIR_XCVR_RX_ONLY, `SBIR_XCVR_RX_TX: begin
          nxt_xctl = i_acc.wdata[2:0];
        end
        default: begin
          nxt_xctl = xctl_ff;
        end
      endcase
    end
    if (force_hit(evt_ff)) begin
      nxt_xctl = {xctl_ff[2], 2'b00};
    end
    nxt_tot = (rd_x ? 1'b0 : tot_ff) | evt_ff.transceiver_overheat;
    nxt_armed = armed_ff;
    nxt_mode  = mode_ff;
    nxt_wdg   = wdg_ff;
    nxt_nr_cnt = nr_cnt_ff;
    case (mode_ff)
      SBIR_NORMAL_REQUEST: begin
        nxt_nr_cnt = nr_cnt_ff + 32'h1;
        if (i_acc.wr && hit(i_acc, `SBIR_ADDR_MODE_CTL)) begin
          nxt_mode = SBIR_NORMAL;
        end else if (nr_cnt_ff >= 32'(NR_CYCLES - 1)) begin
          nxt_mode = SBIR_SLEEP;
        end
      end
      SBIR_NORMAL: begin
        if (i_acc.wr && hit(i_acc, `SBIR_ADDR_MODE_CTL)
            && i_acc.wdata[2:0] != `SBIR_MODE_NORMAL) begin
          nxt_mode = SBIR_STANDBY;
        end
      end
      SBIR_STANDBY: begin
        if (i_acc.wr && hit(i_acc, `SBIR_ADDR_MODE_CTL)) begin
          nxt_armed = (i_acc.wdata[2:0] == `SBIR_MODE_WDG_OFF);
          if (i_acc.wdata[2:0] == `SBIR_MODE_NORMAL && wdg_ff) begin
            nxt_mode = SBIR_NORMAL;
          end
        end else if (i_acc.wr && hit(i_acc, `SBIR_ADDR_MODE_CHK)) begin
          if (armed_ff && i_acc.wdata[2:0] == `SBIR_MODE_WDG_OFF) begin
            nxt_wdg = 1'b0;
          end
          nxt_armed = 1'b0;
        end
      end
      SBIR_SLEEP: begin
        nxt_mode = SBIR_SLEEP;
      end
      default: begin
        nxt_mode = SBIR_SLEEP;
      end
    endcase
  end

  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = `SBIR_ZERO8;
    if (i_acc.rd) begin
      case (i_acc.addr)
        `SBIR_ADDR_SUPPLY_STS: nxt_rdata = {4'h0, sts_lat_ff[2:1],
                                            evt_ff.battery_overvoltage, sts_lat_ff[0]};
        `SBIR_ADDR_MASK_ONE:   nxt_rdata = {4'h0, mask1_ff};
        `SBIR_ADDR_MASK_TWO:   nxt_rdata = {5'h00, mask2_ff};
        `SBIR_ADDR_SRC_ONE:    nxt_rdata = {4'h0, src1};
        `SBIR_ADDR_SRC_TWO:    nxt_rdata = {5'h00, src2};
        `SBIR_ADDR_XCVR:       nxt_rdata = {4'h0, tot_ff, xstate};
        default:               nxt_rdata = `SBIR_ZERO8;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sts_lat_ff      <= 3'h0;
      mask1_ff        <= 4'h0;
      mask2_ff        <= 3'h0;
      xctl_ff         <= 3'h0;
      tot_ff          <= 1'b0;
      armed_ff        <= 1'b0;
      mode_ff         <= SBIR_NORMAL_REQUEST;
      nr_cnt_ff       <= 32'h0;
      wdg_ff          <= 1'b1;
      o_rdata         <= `SBIR_ZERO8;
      o_irq           <= 1'b0;
      o_xcvr_state    <= `SBIR_XCVR_TERM;
      o_main_reg_on   <= 1'b1;
      o_second_reg_on <= 1'b0;
      o_wdg_enabled   <= 1'b1;
      o_mode          <= 2'h0;
    end else begin
      sts_lat_ff      <= nxt_sts_lat;
      mask1_ff        <= nxt_mask1;
      mask2_ff        <= nxt_mask2;
      xctl_ff         <= nxt_xctl;
      tot_ff          <= nxt_tot;
      armed_ff        <= nxt_armed;
      mode_ff         <= nxt_mode;
      nr_cnt_ff       <= nxt_nr_cnt;
      wdg_ff          <= nxt_wdg;
      o_rdata         <= nxt_rdata;
      o_irq           <= |({src1, src2} & {mask1_ff, mask2_ff});
      o_xcvr_state    <= xstate;
      o_main_reg_on   <= (mode_ff != SBIR_SLEEP);
      o_second_reg_on <= i_v2_request && wdg_ff && mode_ff != SBIR_SLEEP;
      o_wdg_enabled   <= wdg_ff;
      o_mode          <= mode_ff;
    end
  end

  // Checks
  property p_mask_clr;
    @(posedge i_clk) disable iff (i_sys_rst)
      rst_pin_low_ff |=> (mask1_ff == 4'h0 && mask2_ff == 3'h0);
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared by reset pin");
  property p_ovl_live;
    @(posedge i_clk) disable iff (i_sys_rst)
      rd_sts |=> o_rdata[`SBIR_STS_OVL_BIT] == $past(evt_ff.battery_overvoltage);
  endproperty
  a_ovl_live: assert property (p_ovl_live) else $error("overvoltage bit not live");
  property p_tot_read;
    @(posedge i_clk) disable iff (i_sys_rst)
      rd_x |=> o_rdata[`SBIR_XCVR_OT_BIT] == $past(tot_ff);
  endproperty
  a_tot_read: assert property (p_tot_read) else $error("overtemp flag not reported");
  property p_sleep_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      mode_ff == SBIR_SLEEP |=> !o_main_reg_on;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("main regulator on in sleep");
  property p_irq;
    @(posedge i_clk) disable iff (i_sys_rst)
      |({src1, src2} & {mask1_ff, mask2_ff}) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_tot_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      (tot_ff && !rd_x) |=> tot_ff;
  endproperty
  a_tot_hold: assert property (p_tot_hold) else $error("overtemp flag lost");
  property p_nowdg;
    @(posedge i_clk) disable iff (i_sys_rst)
      !wdg_ff |=> (!o_second_reg_on && o_xcvr_state == `SBIR_XCVR_TERM);
  endproperty
  a_nowdg: assert property (p_nowdg) else $error("supply or transceiver on without watchdog");
  property p_force;
    @(posedge i_clk) disable iff (i_sys_rst)
      force_hit(evt_ff) |=> (xctl_ff[1:0] == 2'b00);
  endproperty
  a_force: assert property (p_force) else $error("control bits kept on forced termination");
  c_sleep: cover property (@(posedge i_clk) mode_ff == SBIR_SLEEP);
  c_wdg_off: cover property (@(posedge i_clk) $fell(wdg_ff));
  c_irq: cover property (@(posedge i_clk) $rose(o_irq));
endmodule
`default_nettype wire

// ### test/sbir_host.sv
/*
 Host model: a microcontroller issuing register accesses to the bank.
 Assumes strobes are taken at the rising edge and read data follows one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sbir_regs.svh"
module sbir_host (
  // Bus side
  input  wire logic                  i_clk,
  input  wire logic [7:0]            i_rdata,
  output var sbir_pkg::sbir_acc_type o_acc
);
  import sbir_pkg::*;
  initial o_acc = '0;
  // Idle address and data are flipped so a stale value never looks valid
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge i_clk);
    o_acc = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_clk);
    q = i_rdata;
    o_acc = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    acc(1'b0, a, 8'h00, q);
  endtask
  // Trigger word inside the wait window selects normal mode
  task automatic trigger();
    wr(`SBIR_ADDR_MODE_CTL, {5'h00, `SBIR_MODE_NORMAL});
  endtask
  // Only meaningful from stand-by: control first, then check
  task automatic wdg_off();
    wr(`SBIR_ADDR_MODE_CTL, {5'h00, `SBIR_MODE_WDG_OFF});
    wr(`SBIR_ADDR_MODE_CHK, {5'h00, `SBIR_MODE_WDG_OFF});
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
/*
 Self-checking bench for the interrupt and transceiver bank.
 Assumes sbir_pkg, sbir_bank and sbir_host are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sbir_regs.svh"
module tb_top;
  import sbir_pkg::*;
  // Short wait window keeps the run brief
  localparam int NR = 50;
  logic         i_clk, i_sys_rst, i_rst_pin_n, i_v2_request;
  logic         irq, mreg, sreg, wdg;
  logic [2:0]   xs;
  logic [1:0]   mode;
  logic [7:0]   rdata, m1, m2;
  logic [3:0]   lat;
  logic [2:0]   codes [3] = '{3'h0, 3'h2, 3'h3};
  sbir_acc_type acc;
  sbir_evt_type ev;
  int           n_mismatch, compares;
  sbir_bank #(.NR_CYCLES(NR)) i_sbir_bank (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rst_pin_n(i_rst_pin_n), .i_acc(acc),
    .o_rdata(rdata), .i_evt(ev), .i_v2_request(i_v2_request), .o_irq(irq),
    .o_xcvr_state(xs), .o_main_reg_on(mreg), .o_second_reg_on(sreg),
    .o_wdg_enabled(wdg), .o_mode(mode));
  sbir_host i_sbir_host (.i_clk(i_clk), .i_rdata(rdata), .o_acc(acc));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic finish_test();
    $display("Counts: %0d mismatches in %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t register read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_out(input logic [3:0] g, input logic [3:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t output %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_sbir_host.rd(a, q);
    chk_reg(q, e);
  endtask
  // Event inputs pass a three-flop synchroniser first
  task automatic settle();
    repeat (8) @(negedge i_clk);
  endtask
  task automatic wait_mode(input logic [1:0] e);
    int i;
    for (i = 0; i < 40 && mode !== e; i++)
      @(negedge i_clk);
    if (mode !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t mode wait ran out", $time);
      finish_test();
    end else begin
      chk_out({2'h0, mode}, {2'h0, e});
    end
  endtask
  task automatic por();
    i_sys_rst = 1'b1;
    repeat (16) @(negedge i_clk);
    i_sys_rst = 1'b0;
  endtask
  function automatic logic [7:0] src1(sbir_evt_type e, logic uv);
    return {4'h0, e.battery_overvoltage, e.regulator_overheat, e.regulator_prewarning, uv};
  endfunction
  function automatic logic [7:0] src2(sbir_evt_type e);
    return {5'h00, e.can_line_fault, e.serial_error, e.wake_event};
  endfunction
  initial begin
    void'($urandom(59));
    i_rst_pin_n = 1'b1;
    i_v2_request = 1'b0;
    ev = '0;
    lat = 4'h0;
    por();
    chk_out({mode, mreg, wdg}, 4'h3);
    rd_chk(`SBIR_ADDR_MASK_ONE, 8'h00);
    rd_chk(`SBIR_ADDR_MASK_TWO, 8'h00);
    rd_chk(`SBIR_ADDR_SRC_ONE, 8'h00);
    rd_chk(`SBIR_ADDR_SRC_TWO, 8'h00);
    rd_chk(`SBIR_ADDR_XCVR, 8'h00);
    i_sbir_host.rd(`SBIR_ADDR_SUPPLY_STS, m1);
    i_sbir_host.trigger();
    wait_mode(2'h1);
    for (int k = 0; k < 12; k++) begin
      // Transceiver events kept quiet here; they are exercised on their own below
      ev = sbir_evt_type'(11'($urandom) & 11'h7FC);
      m1 = 8'($urandom);
      m2 = 8'($urandom);
      i_sbir_host.wr(`SBIR_ADDR_MASK_ONE, m1);
      i_sbir_host.wr(`SBIR_ADDR_MASK_TWO, m2);
      settle();
      lat = lat | {ev.switch_overheat, ev.second_supply_on, 1'b0, ev.battery_undervoltage};
      rd_chk(`SBIR_ADDR_SRC_ONE, src1(ev, lat[0]));
      rd_chk(`SBIR_ADDR_SRC_TWO, src2(ev));
      rd_chk(`SBIR_ADDR_SRC_ONE, src1(ev, lat[0]));
      rd_chk(`SBIR_ADDR_MASK_ONE, m1 & 8'h0F);
      rd_chk(`SBIR_ADDR_MASK_TWO, m2 & 8'h07);
      chk_out({3'h0, irq}, {3'h0, |((src1(ev, lat[0]) & m1) | (src2(ev) & m2))});
      rd_chk(`SBIR_ADDR_SUPPLY_STS, {4'h0, lat[3:2], ev.battery_overvoltage, lat[0]});
      lat = {ev.switch_overheat, ev.second_supply_on, 1'b0, ev.battery_undervoltage};
      rd_chk(`SBIR_ADDR_SUPPLY_STS, {4'h0, lat[3:2], ev.battery_overvoltage, lat[0]});
    end
    ev = '0;
    settle();
    for (int i = 0; i < 3; i++) begin
      i_sbir_host.wr(`SBIR_ADDR_XCVR, {5'h00, codes[i]});
      rd_chk(`SBIR_ADDR_XCVR, {5'h00, codes[i]});
      chk_out({1'b0, xs}, {1'b0, codes[i]});
    end
    i_v2_request = 1'b1;
    settle();
    chk_out({3'h0, sreg}, 4'h1);
    i_sbir_host.wr(`SBIR_ADDR_XCVR, 8'h01);
    rd_chk(`SBIR_ADDR_XCVR, 8'h03);
    i_sbir_host.wr(`SBIR_ADDR_MASK_ONE, 8'h0F);
    i_sbir_host.wr(`SBIR_ADDR_MASK_TWO, 8'h07);
    i_rst_pin_n = 1'b0;
    settle();
    i_rst_pin_n = 1'b1;
    settle();
    rd_chk(`SBIR_ADDR_MASK_ONE, 8'h00);
    rd_chk(`SBIR_ADDR_MASK_TWO, 8'h00);
    rd_chk(`SBIR_ADDR_XCVR, 8'h03);
    ev.transceiver_overheat = 1'b1;
    settle();
    ev.transceiver_overheat = 1'b0;
    settle();
    rd_chk(`SBIR_ADDR_XCVR, 8'h08);
    rd_chk(`SBIR_ADDR_XCVR, 8'h00);
    i_sbir_host.wr(`SBIR_ADDR_XCVR, 8'h03);
    ev.force_term = 1'b1;
    settle();
    ev.force_term = 1'b0;
    settle();
    rd_chk(`SBIR_ADDR_XCVR, 8'h00);
    i_sbir_host.wr(`SBIR_ADDR_XCVR, 8'h03);
    i_sbir_host.wr(`SBIR_ADDR_MODE_CTL, 8'h00);
    wait_mode(2'h2);
    rd_chk(`SBIR_ADDR_XCVR, 8'h00);
    chk_out({1'b0, xs}, 4'h0);
    i_sbir_host.wdg_off();
    i_v2_request = 1'b1;
    settle();
    chk_out({2'h0, wdg, sreg}, 4'h0);
    i_sbir_host.wr(`SBIR_ADDR_MODE_CTL, 8'h02);
    i_sbir_host.wr(`SBIR_ADDR_XCVR, 8'h03);
    rd_chk(`SBIR_ADDR_XCVR, 8'h00);
    chk_out({2'h0, mode}, 4'h2);
    i_v2_request = 1'b0;
    por();
    repeat (NR + 20) @(negedge i_clk);
    chk_out({mode, mreg, 1'b0}, 4'hC);
    finish_test();
  end
endmodule
`default_nettype wire
